// ==== csr_consts.vh ====
// Constants for the core special register block
`ifndef CSR_CONSTS_VH
`define CSR_CONSTS_VH
`define CSR_ADDR_W        8
`define CSR_OFS_TBLHI     8'h82
`define CSR_OFS_PTRLO     8'h83
`define CSR_OFS_PTRHI     8'h84
`define CSR_OFS_FLAGS     8'h86
`define CSR_OFS_SAVEBUF   8'h87
`define CSR_OFS_PCL       8'hCE
`define CSR_OFS_PCH       8'hCF
`define CSR_OFS_ACC       8'h88
`define CSR_BIT_RST_HI    7
`define CSR_BIT_RST_LO    6
`define CSR_BIT_HI_SUP    5
`define CSR_BIT_MID_SUP   4
`define CSR_BIT_CARRY     2
`define CSR_BIT_HALF      1
`define CSR_BIT_ZERO      0
`define CSR_FLAGS_WMASK   8'hC7
`define CSR_PC_RESET      10'h000
`define CSR_RST_WDT       2'h0
`define CSR_RST_LV        2'h2
`define CSR_RST_EXT       2'h3
`define CSR_OP_NONE       4'h0
`define CSR_OP_STEP       4'h1
`define CSR_OP_GOTO       4'h2
`define CSR_OP_SKIPTEST   4'h3
`define CSR_OP_ALU        4'h4
`define CSR_OP_PCL_ADD    4'h5
`define CSR_OP_PCL_SUB    4'h6
`define CSR_OP_TABLE      4'h7
`define CSR_OP_SAVE       4'h8
`define CSR_OP_RESTORE    4'h9
`define CSR_OP_IRQ        4'hA
`define CSR_SK_BCLR       3'h0
`define CSR_SK_BSET       3'h1
`define CSR_SK_CMP        3'h2
`define CSR_SK_INC        3'h3
`define CSR_SK_DEC        3'h4
`endif

// ==== csr_save_buf.v ====
// Two-word save buffer for working value and status flags
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_save_buf #(
  parameter WIDTH = 8
) (
  input  wire             mclk,
  input  wire             rst,
  input  wire             save,
  input  wire [WIDTH-1:0] acc_in,
  input  wire [WIDTH-1:0] flags_in,
  output reg  [WIDTH-1:0] acc_out,
  output reg  [WIDTH-1:0] flags_out
);
  // Read data comes straight from the storage registers
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      acc_out   <= {WIDTH{1'b0}};
      flags_out <= {WIDTH{1'b0}};
    end else if (save) begin
      acc_out   <= acc_in;
      flags_out <= flags_in;
    end
  end
endmodule

// ==== csr_core_regs.v ====
// Core special registers: flags, program counter, pointers, table byte
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_core_regs #(
  parameter PC_W = 10,
  parameter DW   = 8
) (
  input  wire            mclk,
  input  wire            rst,
  // Register port
  input  wire [7:0]      reg_addr,
  input  wire [DW-1:0]   reg_wdata,
  input  wire            reg_wr,
  input  wire            reg_rd,
  output reg  [DW-1:0]   reg_rdata,
  // Instruction sequencing
  input  wire [3:0]      op_code,
  input  wire [PC_W-1:0] op_target,
  input  wire [2:0]      skip_kind,
  input  wire [DW-1:0]   skip_operand,
  input  wire [2:0]      skip_bit,
  input  wire [DW-1:0]   alu_result,
  input  wire            alu_carry,
  input  wire            alu_half,
  input  wire            alu_write_acc,
  input  wire [15:0]     rom_word,
  // Reset cause and supply detectors
  input  wire [1:0]      reset_cause,
  input  wire            reset_cause_load,
  input  wire            high_threshold_option,
  input  wire            mid_threshold_option,
  input  wire            high_det_low,
  input  wire            mid_det_low,
  // Observed state
  output reg  [PC_W-1:0] instruction_pointer,
  output reg  [DW-1:0]   status_flags,
  output reg  [DW-1:0]   working_value,
  output reg  [DW-1:0]   table_high_byte,
  output reg  [DW-1:0]   rom_addr_hi,
  output reg  [DW-1:0]   rom_addr_lo,
  output reg  [DW-1:0]   ram_bank,
  output reg  [DW-1:0]   ram_index,
  output reg             skip_taken
);

  // ==========================================================
  // Helpers
  // ==========================================================
  function sel_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      sel_hit = (a == ofs);
    end
  endfunction

  reg  [PC_W-1:0] pc_q;
  reg  [PC_W-1:0] pc_d;
  reg  [DW-1:0]   flg_q;
  reg  [DW-1:0]   flg_d;
  reg  [DW-1:0]   acc_q;
  reg  [DW-1:0]   acc_d;
  reg  [DW-1:0]   tbl_q;
  reg  [DW-1:0]   tbl_d;
  reg  [DW-1:0]   ptr_lo_q;
  reg  [DW-1:0]   ptr_hi_q;
  reg             cond;
  reg  [8:0]      pcl_sum;
  wire [DW-1:0]   buf_acc;
  wire [DW-1:0]   buf_flg;
  wire            do_save;
  wire [DW-1:0]   sup_bits;

  assign do_save = (op_code == `CSR_OP_SAVE);

  csr_save_buf #(
    .WIDTH (DW)
  ) u_save (
    .mclk      (mclk),
    .rst       (rst),
    .save      (do_save),
    .acc_in    (acc_q),
    .flags_in  (flg_q),
    .acc_out   (buf_acc),
    .flags_out (buf_flg)
  );

  // ==========================================================
  // Supply flags
  // ==========================================================
  // Detector bits read zero when their option is off
  assign sup_bits = {2'b00, high_det_low & high_threshold_option,
                     mid_det_low & mid_threshold_option, 4'h0};

  // ==========================================================
  // Skip condition
  // ==========================================================
  always @* begin
    cond = 1'b0;
    case (skip_kind)
      `CSR_SK_BCLR: cond = ~skip_operand[skip_bit];
      `CSR_SK_BSET: cond = skip_operand[skip_bit];
      `CSR_SK_CMP:  cond = (acc_q == skip_operand);
      `CSR_SK_INC:  cond = (skip_operand == 8'hFF);
      `CSR_SK_DEC:  cond = (skip_operand == 8'h00);
      default:      cond = 1'b0;
    endcase
  end

  // ==========================================================
  // Next-state logic
  // ==========================================================
  always @* begin
    pc_d    = pc_q;
    flg_d   = flg_q;
    acc_d   = acc_q;
    tbl_d   = tbl_q;
    pcl_sum = {1'b0, pc_q[7:0]} + {1'b0, acc_q};
    case (op_code)
      `CSR_OP_STEP: begin
        pc_d = pc_q + 10'h001;
      end
      `CSR_OP_GOTO: begin
        pc_d = op_target;
      end
      `CSR_OP_SKIPTEST: begin
        // Only the counter moves; the skipped word changes nothing
        pc_d = cond ? pc_q + 10'h002 : pc_q + 10'h001;
      end
      `CSR_OP_ALU: begin
        pc_d = pc_q + 10'h001;
        flg_d[`CSR_BIT_CARRY] = alu_carry;
        flg_d[`CSR_BIT_HALF]  = alu_half;
        flg_d[`CSR_BIT_ZERO]  = (alu_result == 8'h00);
        if (alu_write_acc) begin
          acc_d = alu_result;
        end
      end
      `CSR_OP_PCL_ADD: begin
        pc_d = {pc_q[9:8] + {1'b0, pcl_sum[8]}, pcl_sum[7:0]};
      end
      `CSR_OP_PCL_SUB: begin
        // Page stays put: the high byte only ever follows upward carries
        pc_d = {pc_q[9:8], pc_q[7:0] - acc_q};
      end
      `CSR_OP_TABLE: begin
        pc_d  = pc_q + 10'h001;
        tbl_d = rom_word[15:8];
        acc_d = rom_word[7:0];
      end
      `CSR_OP_SAVE: begin
        pc_d = pc_q + 10'h001;
      end
      `CSR_OP_RESTORE: begin
        pc_d  = pc_q + 10'h001;
        acc_d = buf_acc;
        flg_d = (buf_flg & `CSR_FLAGS_WMASK);
      end
      `CSR_OP_IRQ: begin
        // Entry redirects only the counter; software must save state
        pc_d = op_target;
      end
      default: begin
        pc_d = pc_q;
      end
    endcase
    if (reg_wr) begin
      if (sel_hit(reg_addr, `CSR_OFS_FLAGS)) begin
        flg_d = reg_wdata & `CSR_FLAGS_WMASK;
      end else if (sel_hit(reg_addr, `CSR_OFS_PCL)) begin
        pc_d = {pc_q[9:8], reg_wdata};
      end else if (sel_hit(reg_addr, `CSR_OFS_PCH)) begin
        pc_d = {reg_wdata[1:0], pc_q[7:0]};
      end else if (sel_hit(reg_addr, `CSR_OFS_TBLHI)) begin
        tbl_d = reg_wdata;
      end
      // Working value has no register address; software cannot write it here
    end
    // Hardware cause capture wins over a software write
    if (reset_cause_load) begin
      flg_d[7:6] = reset_cause;
    end
  end

  // ==========================================================
  // State registers
  // ==========================================================
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pc_q     <= `CSR_PC_RESET;
      flg_q    <= 8'h00;
      acc_q    <= 8'h00;
      tbl_q    <= 8'h00;
      ptr_lo_q <= 8'h00;
      ptr_hi_q <= 8'h00;
    end else begin
      pc_q  <= pc_d;
      flg_q <= flg_d;
      acc_q <= acc_d;
      tbl_q <= tbl_d;
      if (reg_wr && sel_hit(reg_addr, `CSR_OFS_PTRLO)) begin
        ptr_lo_q <= reg_wdata;
      end
      if (reg_wr && sel_hit(reg_addr, `CSR_OFS_PTRHI)) begin
        ptr_hi_q <= reg_wdata;
      end
    end
  end

  // ==========================================================
  // Register read port and registered outputs
  // ==========================================================
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata           <= 8'h00;
      instruction_pointer <= `CSR_PC_RESET;
      status_flags        <= 8'h00;
      working_value       <= 8'h00;
      table_high_byte     <= 8'h00;
      rom_addr_hi         <= 8'h00;
      rom_addr_lo         <= 8'h00;
      ram_bank            <= 8'h00;
      ram_index           <= 8'h00;
      skip_taken          <= 1'b0;
    end else begin
      if (reg_rd) begin
        if (sel_hit(reg_addr, `CSR_OFS_FLAGS)) begin
          reg_rdata <= (flg_q & `CSR_FLAGS_WMASK) | sup_bits;
        end else if (sel_hit(reg_addr, `CSR_OFS_PCL)) begin
          reg_rdata <= pc_q[7:0];
        end else if (sel_hit(reg_addr, `CSR_OFS_PCH)) begin
          reg_rdata <= {6'h00, pc_q[9:8]};
        end else if (sel_hit(reg_addr, `CSR_OFS_TBLHI)) begin
          reg_rdata <= tbl_q;
        end else if (sel_hit(reg_addr, `CSR_OFS_PTRLO)) begin
          reg_rdata <= ptr_lo_q;
        end else if (sel_hit(reg_addr, `CSR_OFS_PTRHI)) begin
          reg_rdata <= ptr_hi_q;
        end else begin
          // Working value and unmapped offsets read as zero
          reg_rdata <= 8'h00;
        end
      end else begin
        reg_rdata <= 8'h00;
      end
      instruction_pointer <= pc_d;
      status_flags        <= (flg_d & `CSR_FLAGS_WMASK) | sup_bits;
      working_value       <= acc_d;
      table_high_byte     <= tbl_d;
      rom_addr_hi         <= ptr_hi_q;
      rom_addr_lo         <= ptr_lo_q;
      ram_bank            <= ptr_hi_q;
      ram_index           <= ptr_lo_q;
      skip_taken          <= (op_code == `CSR_OP_SKIPTEST) && cond;
    end
  end
endmodule

// ==== csr_core_regs_checker.sv ====
// Port-level assertions for the core special registers
`timescale 1ns/1ps
`include "csr_consts.vh"
module csr_core_regs_checker #(
  parameter PC_W = 10,
  parameter DW   = 8
) (
  input wire            mclk,
  input wire            rst,
  input wire            reg_rd,
  input wire [3:0]      op_code,
  input wire [PC_W-1:0] op_target,
  input wire [15:0]     rom_word,
  input wire            high_threshold_option,
  input wire [DW-1:0]   reg_rdata,
  input wire [PC_W-1:0] instruction_pointer,
  input wire [DW-1:0]   status_flags,
  input wire [DW-1:0]   working_value,
  input wire [DW-1:0]   table_high_byte,
  input wire            skip_taken
);
  // ====
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_reset_pc_zero: assert property ($fell(rst) |-> instruction_pointer == 0)
    else $error("pc not zero after reset");
  a_step_adds_one: assert property (op_code == `CSR_OP_STEP |=>
    instruction_pointer == $past(instruction_pointer) + 1'b1) else $error("step wrong");
  a_goto_loads_pc: assert property (op_code == `CSR_OP_GOTO |=>
    instruction_pointer == $past(op_target)) else $error("goto wrong");
  a_skip_adds_two: assert property (skip_taken |-> $past(op_code) == `CSR_OP_SKIPTEST
    && instruction_pointer == $past(instruction_pointer) + 2'd2) else $error("skip wrong");
  a_flag_bit_three: assert property (status_flags[3] == 1'b0)
    else $error("flag bit 3 set");
  a_supply_masked: assert property (!high_threshold_option &&
    !$past(high_threshold_option) |-> !status_flags[5]) else $error("supply bit unmasked");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 0)
    else $error("read data outside read cycle");
  a_table_split: assert property (op_code == `CSR_OP_TABLE |=>
    table_high_byte == $past(rom_word[15:8]) && working_value == $past(rom_word[7:0]))
    else $error("table read split wrong");
  a_sub_keeps_high: assert property (op_code == `CSR_OP_PCL_SUB |=>
    instruction_pointer[9:8] == $past(instruction_pointer[9:8])) else $error("high moved");
endmodule
bind csr_core_regs csr_core_regs_checker #(.PC_W(PC_W), .DW(DW)) i_chk (
  .mclk(mclk), .rst(rst), .reg_rd(reg_rd), .op_code(op_code), .op_target(op_target),
  .rom_word(rom_word), .high_threshold_option(high_threshold_option),
  .reg_rdata(reg_rdata), .instruction_pointer(instruction_pointer),
  .status_flags(status_flags), .working_value(working_value),
  .table_high_byte(table_high_byte), .skip_taken(skip_taken));

// ==== cpu_core_special_registers_tb.sv ====
// Directed bench for the core special registers
`timescale 1ns/1ps
`include "csr_consts.vh"
module cpu_core_special_registers_tb;
  reg         mclk, rst, wr_q, rd_q, cy, hc, wacc, rcl, hopt, mopt, hlow, mlow;
  reg  [7:0]  addr, wdat, sop, ares;
  reg  [3:0]  opc;
  reg  [9:0]  tgt, p;
  reg  [2:0]  sk, sb;
  reg  [15:0] rom;
  reg  [1:0]  rc;
  reg  [14:0] tab [0:8];
  wire [7:0]  rdat, flags, acc, tbl, rhi, rlo, bank, idx;
  wire [9:0]  ip;
  wire        skt;
  integer     errors, n_compared, cyc, i;
  csr_core_regs i_csr_core_regs (.mclk(mclk), .rst(rst), .reg_addr(addr), .reg_wdata(wdat),
    .reg_wr(wr_q), .reg_rd(rd_q), .reg_rdata(rdat), .op_code(opc), .op_target(tgt),
    .skip_kind(sk), .skip_operand(sop), .skip_bit(sb), .alu_result(ares), .alu_carry(cy),
    .alu_half(hc), .alu_write_acc(wacc), .rom_word(rom), .reset_cause(rc),
    .reset_cause_load(rcl), .high_threshold_option(hopt), .mid_threshold_option(mopt),
    .high_det_low(hlow), .mid_det_low(mlow), .instruction_pointer(ip), .status_flags(flags),
    .working_value(acc), .table_high_byte(tbl), .rom_addr_hi(rhi), .rom_addr_lo(rlo),
    .ram_bank(bank), .ram_index(idx), .skip_taken(skt));
  // ====
  // Tasks
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge mclk);
      addr <= a;
      wdat <= d;
      wr_q <= 1'b1;
      @(posedge mclk);
      wr_q <= 1'b0;
      #1;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge mclk);
      addr <= a;
      rd_q <= 1'b1;
      @(posedge mclk);
      rd_q <= 1'b0;
      #1 chk(rdat, exp);
    end
  endtask
  task op(input [3:0] c);
    begin
      @(posedge mclk);
      opc <= c;
      @(posedge mclk);
      opc <= `CSR_OP_NONE;
      #1;
    end
  endtask
  task alu(input [7:0] r, input c, input h);
    begin
      @(posedge mclk);
      ares <= r;
      cy   <= c;
      hc   <= h;
      op(`CSR_OP_ALU);
    end
  endtask
  task end_of_test;
    begin
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Hang guard, well above the fewer than two hundred cycles the sequence needs
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      end_of_test;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ====
  // Sequence
  initial begin
    {rst, wr_q, rd_q, cy, hc, wacc, rcl, hopt, mopt, hlow, mlow} = 11'h460;
    {addr, wdat, sop, ares, opc, tgt, sk, sb, rom, rc} = 0;
    errors = 0;
    n_compared = 0;
    cyc = 0;
    // Entry: kind, bit index, operand, skip expected
    tab[0] = {`CSR_SK_BCLR, 3'd0, 8'hFE, 1'b1};
    tab[1] = {`CSR_SK_BCLR, 3'd7, 8'hFE, 1'b0};
    tab[2] = {`CSR_SK_BSET, 3'd3, 8'h08, 1'b1};
    tab[3] = {`CSR_SK_CMP, 3'd0, 8'h20, 1'b1};
    tab[4] = {`CSR_SK_CMP, 3'd0, 8'h21, 1'b0};
    tab[5] = {`CSR_SK_INC, 3'd0, 8'hFF, 1'b1};
    tab[6] = {`CSR_SK_INC, 3'd0, 8'hFE, 1'b0};
    tab[7] = {`CSR_SK_DEC, 3'd0, 8'h00, 1'b1};
    tab[8] = {`CSR_SK_DEC, 3'd0, 8'h01, 1'b0};
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(ip, 0);
    rd(`CSR_OFS_PCL, 8'h00);
    wr(`CSR_OFS_PTRLO, 8'h25);
    wr(`CSR_OFS_PTRHI, 8'h01);
    wr(8'h85, 8'hFF);
    rd(`CSR_OFS_PTRLO, 8'h25);
    rd(8'h85, 8'h00);
    chk({bank, idx}, 16'h0125);
    chk({rhi, rlo}, 16'h0125);
    wr(`CSR_OFS_FLAGS, 8'hFF);
    rd(`CSR_OFS_FLAGS, 8'hC7);
    @(posedge mclk);
    {hopt, mopt, hlow} <= 3'b111;
    wr(`CSR_OFS_FLAGS, 8'h00);
    rd(`CSR_OFS_FLAGS, 8'h20);
    @(posedge mclk);
    mlow <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(`CSR_OFS_FLAGS, 8'h30);
    @(posedge mclk);
    {hopt, mopt} <= 2'b00;
    repeat (3) @(posedge mclk);
    rd(`CSR_OFS_FLAGS, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      @(posedge mclk);
      rc  <= i[1:0];
      rcl <= 1'b1;
      @(posedge mclk);
      rcl <= 1'b0;
      #1 chk(flags[7:6], i[1:0]);
    end
    $display("test flags and pointers done");
    alu(8'h00, 1'b1, 1'b0);
    chk(flags[2:0], 3'b101);
    alu(8'h5A, 1'b0, 1'b1);
    chk({flags[2:0], acc}, {3'b010, 8'h5A});
    @(posedge mclk);
    wacc <= 1'b0;
    alu(8'h77, 1'b1, 1'b1);
    chk({flags[2:0], acc}, {3'b110, 8'h5A});
    @(posedge mclk);
    wacc <= 1'b1;
    wr(`CSR_OFS_PCH, 8'h03);
    wr(`CSR_OFS_PCL, 8'h23);
    chk(ip, 10'h323);
    wr(`CSR_OFS_PCL, 8'h28);
    chk(ip, 10'h328);
    wr(`CSR_OFS_PCL, 8'hFF);
    op(`CSR_OP_STEP);
    chk(ip, 10'h000);
    wr(`CSR_OFS_PCH, 8'h01);
    wr(`CSR_OFS_PCL, 8'hF0);
    alu(8'h20, 1'b0, 1'b0);
    op(`CSR_OP_PCL_ADD);
    chk(ip, 10'h211);
    op(`CSR_OP_PCL_SUB);
    chk(ip, 10'h2F1);
    @(posedge mclk);
    tgt <= 10'h2AB;
    op(`CSR_OP_GOTO);
    chk(ip, 10'h2AB);
    rd(`CSR_OFS_PCH, 8'h02);
    for (i = 0; i < 9; i = i + 1) begin
      @(posedge mclk);
      {sk, sb, sop} <= tab[i][14:1];
      p = ip;
      op(`CSR_OP_SKIPTEST);
      chk(ip, p + (tab[i][0] ? 10'd2 : 10'd1));
      chk(skt, tab[i][0]);
      chk({acc, flags}, 16'h20C0);
    end
    $display("test program counter done");
    @(posedge mclk);
    rom <= 16'hA55A;
    op(`CSR_OP_TABLE);
    chk({tbl, acc}, 16'hA55A);
    wr(`CSR_OFS_ACC, 8'hEE);
    rd(`CSR_OFS_ACC, 8'h00);
    wr(`CSR_OFS_FLAGS, 8'h85);
    op(`CSR_OP_SAVE);
    alu(8'h00, 1'b0, 1'b0);
    wr(`CSR_OFS_FLAGS, 8'h00);
    op(`CSR_OP_RESTORE);
    chk({acc, flags}, 16'h5A85);
    @(posedge mclk);
    tgt <= 10'h004;
    op(`CSR_OP_IRQ);
    chk({acc, flags}, 16'h5A85);
    chk(ip, 10'h004);
    @(posedge mclk);
    rst <= 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    #1 chk(ip, 10'h000);
    chk(flags, 8'h00);
    op(`CSR_OP_STEP);
    chk(ip, 10'h001);
    $display("test table save and reset done");
    end_of_test;
  end
endmodule
